// file: psr_ecu_model.sv
// Link receiver model: sends one sync pulse on each request.
// Assumes the bench spaces its requests past every frame it expects.
`timescale 1ns/1ps
module psr_ecu_model #(
  parameter int PULSE_CYC = 8
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic fire_i,
  output logic sync_o
);
  int cnt_q; // Cycles left in the pulse
  // Pulse shaper; the line rests low between pulses
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_q <= 0;
      sync_o <= 1'b0;
    end else if (fire_i) begin
      cnt_q <= PULSE_CYC;
      sync_o <= 1'b1;
    end else if (cnt_q > 1) begin
      cnt_q <= cnt_q - 1;
    end else begin
      cnt_q <= 0;
      sync_o <= 1'b0;
    end
  end
endmodule

// file: psr_pkg.sv
// Shared constants and types for the response scheduler.
// Assumes a single 125 MHz clock and a word-wide plain register port.
package psr_pkg;
  // Clock and time base
  localparam int CLK_PERIOD_NS = 8;
  localparam int HALF_US_NS = 500;
  localparam int FREE_RUN_PERIOD_NS = 228000;
  localparam int FREE_RUN_CYC = FREE_RUN_PERIOD_NS / CLK_PERIOD_NS;
  localparam int FRAME_HALF_US = 208;
  localparam int REPORT_MSGS = 2;
  // Nominal phase-three lengths, one retry, in hundredths of a millisecond
  localparam int P3_ASYNC8_R1_CMS = 8231;
  localparam int P3_ASYNC10_R1_CMS = 9690;
  localparam int P3_SYNC8_R1_CMS = 7000;
  // Transmission mode field codes
  localparam logic [1:0] MODE_NORMAL = 2'h0;
  localparam logic [1:0] MODE_DOUBLE = 2'h1;
  // Configuration field positions
  localparam int CFG_MODE_LSB = 0;
  localparam int CFG_FREE_BIT = 2;
  localparam int CFG_LAT_BIT = 3;
  localparam int CFG_LOCK_BIT = 4;
  localparam int CFG_RPT_LSB = 5;
  // Register byte offsets
  localparam logic [7:0] OFS_CONFIG = 8'h00;
  localparam logic [7:0] OFS_SLOT_A = 8'h04;
  localparam logic [7:0] OFS_SLOT_B = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0c;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h10;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h14;
  // Reset values
  localparam logic [7:0] RST_CONFIG = 8'h20;
  localparam logic [9:0] RST_SLOT_A = 10'h000;
  localparam logic [9:0] RST_SLOT_B = 10'h000;
  localparam logic [3:0] RST_IRQ_MASK = 4'h0;
  // Interrupt event bits
  localparam int EV_TX = 0;
  localparam int EV_ST_FAIL = 1;
  localparam int EV_REPORT = 2;
  localparam int EV_B_DROP = 3;
  // Message kinds and status message words
  localparam logic [1:0] KIND_DATA = 2'h0;
  localparam logic [1:0] KIND_BUSY = 2'h1;
  localparam logic [1:0] KIND_READY = 2'h2;
  localparam logic [1:0] KIND_DEFECT = 2'h3;
  localparam logic [9:0] WORD_BUSY = 10'h1e3;
  localparam logic [9:0] WORD_READY = 10'h1e4;
  localparam logic [9:0] WORD_DEFECT = 10'h1e5;
  // Scheduler states
  typedef enum logic [2:0] {S_EARLY, S_BUSY, S_REPORT, S_NORMAL, S_PROG} psr_state_t;
endpackage

// file: psr_response_scheduler.sv
// Response scheduler: phase-three self-check reporting and slot timing.
// Assumes a sync pin from the link receiver, samples on the same clock.
`timescale 1ns/1ps
module psr_response_scheduler
  import psr_pkg::*;
#(
  parameter int FREE_RUN_CYCLES = psr_pkg::FREE_RUN_CYC,
  parameter int FRAME_LEN_HU = psr_pkg::FRAME_HALF_US
) (
  input wire logic CLK_I,
  input wire logic RST_I,
  input wire logic SYNC_I,
  input wire logic [9:0] SAMPLE_I,
  input wire logic INIT12_DONE_I,
  input wire logic SELFTEST_DONE_I,
  input wire logic SELFTEST_PASS_I,
  input wire logic PROG_CMD_I,
  input wire logic [7:0] ADDR_I,
  input wire logic [31:0] WDATA_I,
  input wire logic WE_I,
  input wire logic RE_I,
  output logic [31:0] RDATA_O,
  output logic TX_START_O,
  output logic TX_SLOT_B_O,
  output logic [1:0] TX_KIND_O,
  output logic [9:0] TX_DATA_O,
  output logic SELFTEST_START_O,
  output logic PROG_MODE_O,
  output logic IRQ_O
);
  import psr_pkg::*;

  localparam int FRW = $clog2(FREE_RUN_CYCLES);

  // Parameter sanity
  if (FREE_RUN_CYCLES < 2 || FRAME_LEN_HU < 1 || FRAME_LEN_HU > 1023) begin : g_bad
    $error("unsupported scheduler parameters");
  end

  // Mode decode shared by the scheduler and the status register
  function automatic logic is_free_running_select(input logic [7:0] cfg, input logic [9:0] sa);
    is_free_running_select = (cfg[CFG_MODE_LSB +: 2] == MODE_NORMAL) && cfg[CFG_FREE_BIT]
               && (sa == 10'h000);
  endfunction

  // Configuration and interrupt registers
  logic [7:0] config_q; // Mode, free run, latency, lock, retries
  logic [9:0] slot_a_q; // First slot offset
  logic [9:0] slot_b_q; // Second slot offset
  logic [3:0] irq_stat_q; // Sticky events
  logic [3:0] irq_mask_q; // Event enables
  logic [3:0] events; // Events of this cycle

  // Link side
  logic sync_meta_q; // First synchroniser stage
  logic sync_q; // Second synchroniser stage
  logic sync_prev_q; // For edge detection
  logic sync_rise; // Sync rising edge
  logic [9:0] acc_q; // Fractional half-microsecond divider
  logic tick_hu; // Half-microsecond enable
  logic [FRW-1:0] fr_cnt_q; // Free-running period counter
  logic fr_fire; // Free-running frame moment

  // Scheduler state
  psr_state_t state_q; // Current phase
  psr_state_t state_d; // Next phase
  logic [2:0] try_q; // Self-test repetitions used
  logic passed_q; // Self-test outcome
  logic [1:0] rep_cnt_q; // Ready or defect messages sent
  logic st_start_q; // Self-test start pulse
  logic [9:0] data_a_q; // Sample for the first slot
  logic [9:0] data_b_q; // Sample for the second slot

  // Decoded settings
  logic [1:0] mode_sel; // Transmission mode field
  logic free_running_select_mode; // Fixed-rate mode
  logic simul_mode; // Latch at sync edge
  logic minlat_mode; // Latch at slot A
  logic double_mode; // Two slots per sync
  logic conflict; // Slot B starts inside slot A frame
  logic hit_a; // Slot A offset reached
  logic hit_b; // Slot B offset reached
  logic send_a; // First slot frame starts
  logic send_b; // Second slot frame starts
  logic drop_b; // Second slot frame suppressed
  logic talking; // Phase in which frames go out
  logic [1:0] cur_kind; // Kind of message now due
  logic [9:0] cur_word; // Status word now due
  logic [10:0] a_end; // End of slot A frame

  assign mode_sel = config_q[CFG_MODE_LSB +: 2];
  assign free_running_select_mode = is_free_running_select(config_q, slot_a_q);
  assign simul_mode = (mode_sel == MODE_NORMAL) && !free_running_select_mode && !config_q[CFG_LAT_BIT];
  assign minlat_mode = (mode_sel == MODE_NORMAL) && !free_running_select_mode && config_q[CFG_LAT_BIT];
  assign double_mode = (mode_sel == MODE_DOUBLE);

  // Conflict when slot B starts while the slot A frame is on the line
  assign a_end = {1'b0, slot_a_q} + FRAME_LEN_HU[10:0];
  assign conflict = (slot_b_q >= slot_a_q) && ({1'b0, slot_b_q} < a_end);

  // Sync pin synchroniser, first stage read by the second only
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      sync_meta_q <= 1'b0;
      sync_q <= 1'b0;
      sync_prev_q <= 1'b0;
    end else begin
      sync_meta_q <= SYNC_I;
      sync_q <= sync_meta_q;
      sync_prev_q <= sync_q;
    end
  end

  // Fixed-rate mode does not follow the sync pulses
  assign sync_rise = sync_q && !sync_prev_q && !free_running_select_mode;

  // Half-microsecond divider, 62.5 cycles on average, realigned at sync
  assign tick_hu = (acc_q + CLK_PERIOD_NS[9:0]) >= HALF_US_NS[9:0];
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      acc_q <= 10'h000;
    end else if (sync_rise) begin
      acc_q <= 10'h000;
    end else if (tick_hu) begin
      acc_q <= acc_q + CLK_PERIOD_NS[9:0] - HALF_US_NS[9:0];
    end else begin
      acc_q <= acc_q + CLK_PERIOD_NS[9:0];
    end
  end

  // Two slot timers, A then B
  psr_slot_if sif [2] ();
  for (genvar g = 0; g < 2; g++) begin : g_slot
    assign sif[g].tick = tick_hu;
    assign sif[g].restart = sync_rise;
    assign sif[g].offset = (g == 0) ? slot_a_q : slot_b_q;
    psr_slot_timer u_timer (
      .clk_i(CLK_I),
      .rst_i(RST_I),
      .sif(sif[g])
    );
  end
  assign hit_a = sif[0].hit;
  assign hit_b = sif[1].hit;

  // Free-running frame period counter
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      fr_cnt_q <= '0;
    end else if (!free_running_select_mode || fr_fire) begin
      fr_cnt_q <= '0;
    end else begin
      fr_cnt_q <= fr_cnt_q + 1'b1;
    end
  end
  assign fr_fire = free_running_select_mode && (fr_cnt_q == FRW'(FREE_RUN_CYCLES - 1));

  // Frame start decisions
  assign talking = (state_q == S_BUSY) || (state_q == S_REPORT) || (state_q == S_NORMAL);
  assign send_a = talking && (free_running_select_mode ? fr_fire : hit_a);
  assign send_b = talking && !free_running_select_mode && double_mode && hit_b && !conflict;
  assign drop_b = talking && !free_running_select_mode && double_mode && hit_b && conflict;

  // Message due in the current phase
  always_comb begin
    cur_kind = KIND_DATA;
    cur_word = WORD_BUSY;
    unique case (state_q)
      S_BUSY: begin
        cur_kind = KIND_BUSY;
        cur_word = WORD_BUSY;
      end
      S_REPORT: begin
        cur_kind = passed_q ? KIND_READY : KIND_DEFECT;
        cur_word = passed_q ? WORD_READY : WORD_DEFECT;
      end
      S_EARLY, S_NORMAL, S_PROG: begin
        cur_kind = KIND_DATA;
        cur_word = WORD_BUSY;
      end
    endcase
  end

  // Phase sequencing
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      S_EARLY: begin
        if (free_running_select_mode && PROG_CMD_I && !config_q[CFG_LOCK_BIT]) begin
          state_d = S_PROG;
        end else if (INIT12_DONE_I) begin
          state_d = S_BUSY;
        end
      end
      S_BUSY: begin
        if (SELFTEST_DONE_I && (SELFTEST_PASS_I || try_q >= config_q[CFG_RPT_LSB +: 3])) begin
          state_d = S_REPORT;
        end
      end
      S_REPORT: begin
        if (passed_q && send_a && rep_cnt_q == 2'(REPORT_MSGS - 1)) begin
          state_d = S_NORMAL;
        end
      end
      S_NORMAL, S_PROG: begin
        state_d = state_q;
      end
    endcase
  end

  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      state_q <= S_EARLY;
    end else begin
      state_q <= state_d;
    end
  end

  assign PROG_MODE_O = (state_q == S_PROG);

  // Self-test run control and repetition count
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      st_start_q <= 1'b0;
      try_q <= 3'h0;
      passed_q <= 1'b0;
    end else begin
      st_start_q <= 1'b0;
      if (state_q == S_EARLY && state_d == S_BUSY) begin
        st_start_q <= 1'b1;
        try_q <= 3'h0;
      end else if (state_q == S_BUSY && SELFTEST_DONE_I) begin
        if (SELFTEST_PASS_I) begin
          passed_q <= 1'b1;
        end else if (try_q < config_q[CFG_RPT_LSB +: 3]) begin
          try_q <= try_q + 3'h1;
          st_start_q <= 1'b1;
        end
      end
    end
  end
  assign SELFTEST_START_O = st_start_q;

  // Ready or defect messages counted in slot A frames
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      rep_cnt_q <= 2'h0;
    end else if (state_q != S_REPORT) begin
      rep_cnt_q <= 2'h0;
    end else if (send_a && rep_cnt_q != 2'h3) begin
      rep_cnt_q <= rep_cnt_q + 2'h1;
    end
  end

  // Sample latch for the first slot
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      data_a_q <= 10'h000;
    end else if (simul_mode && sync_rise) begin
      data_a_q <= SAMPLE_I;
    end else if ((minlat_mode || double_mode) && hit_a) begin
      data_a_q <= SAMPLE_I;
    end else if (fr_fire) begin
      data_a_q <= SAMPLE_I;
    end
  end

  // Fresh sample for the second slot
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      data_b_q <= 10'h000;
    end else if (double_mode && hit_b) begin
      data_b_q <= SAMPLE_I;
    end
  end

  // Frame start to the line driver; sample words come from the slot A latch in sync-edge mode, else straight from SAMPLE_I
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      TX_START_O <= 1'b0;
      TX_SLOT_B_O <= 1'b0;
      TX_KIND_O <= KIND_DATA;
      TX_DATA_O <= 10'h000;
    end else begin
      TX_START_O <= send_a || send_b;
      if (send_a || send_b) begin
        TX_SLOT_B_O <= send_b;
        TX_KIND_O <= cur_kind;
        if (cur_kind != KIND_DATA) begin
          TX_DATA_O <= cur_word;
        end else if (send_b) begin
          TX_DATA_O <= SAMPLE_I;
        end else if (simul_mode) begin
          TX_DATA_O <= data_a_q;
        end else begin
          TX_DATA_O <= SAMPLE_I;
        end
      end
    end
  end

  // Events for the interrupt status
  assign events = {drop_b, (state_q == S_BUSY && state_d == S_REPORT),
                   (state_q == S_BUSY && SELFTEST_DONE_I && !SELFTEST_PASS_I),
                   (send_a || send_b)};

  // Software registers
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      config_q <= RST_CONFIG;
      slot_a_q <= RST_SLOT_A;
      slot_b_q <= RST_SLOT_B;
      irq_mask_q <= RST_IRQ_MASK;
    end else if (WE_I) begin
      unique case (ADDR_I)
        OFS_CONFIG: config_q <= WDATA_I[7:0];
        OFS_SLOT_A: slot_a_q <= WDATA_I[9:0];
        OFS_SLOT_B: slot_b_q <= WDATA_I[9:0];
        OFS_IRQ_MASK: irq_mask_q <= WDATA_I[3:0];
        default: begin
        end
      endcase
    end
  end

  // Sticky events, write one to clear, a new event wins
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      irq_stat_q <= 4'h0;
    end else if (WE_I && ADDR_I == OFS_IRQ_STAT) begin
      irq_stat_q <= (irq_stat_q & ~WDATA_I[3:0]) | events;
    end else begin
      irq_stat_q <= irq_stat_q | events;
    end
  end
  assign IRQ_O = |(irq_stat_q & irq_mask_q);

  // Read data, one cycle after the strobe, zero elsewhere
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      RDATA_O <= 32'h0000_0000;
    end else if (RE_I) begin
      unique case (ADDR_I)
        OFS_CONFIG: RDATA_O <= {24'h000000, config_q};
        OFS_SLOT_A: RDATA_O <= {22'h000000, slot_a_q};
        OFS_SLOT_B: RDATA_O <= {22'h000000, slot_b_q};
        OFS_STATUS: RDATA_O <= {20'h00000, conflict, double_mode, free_running_select_mode, passed_q,
                                try_q, 1'b0, 1'b0, state_q};
        OFS_IRQ_STAT: RDATA_O <= {28'h0000000, irq_stat_q};
        OFS_IRQ_MASK: RDATA_O <= {28'h0000000, irq_mask_q};
        default: RDATA_O <= 32'h0000_0000;
      endcase
    end else begin
      RDATA_O <= 32'h0000_0000;
    end
  end

  // Checks next to the logic
  a_retry_limit: assert property (@(posedge CLK_I) disable iff (RST_I)
    state_q == S_BUSY && SELFTEST_DONE_I && !SELFTEST_PASS_I
    && try_q >= config_q[CFG_RPT_LSB +: 3]
    |=> state_q == S_REPORT && !passed_q && !SELFTEST_START_O)
    else $error("retry limit not honoured");
  a_retry_again: assert property (@(posedge CLK_I) disable iff (RST_I)
    state_q == S_BUSY && SELFTEST_DONE_I && !SELFTEST_PASS_I
    && try_q < config_q[CFG_RPT_LSB +: 3]
    |=> SELFTEST_START_O && state_q == S_BUSY && try_q == $past(try_q) + 3'h1)
    else $error("failed self-test not rerun");
  a_pass_stops: assert property (@(posedge CLK_I) disable iff (RST_I)
    state_q == S_BUSY && SELFTEST_DONE_I && SELFTEST_PASS_I
    |=> passed_q && state_q == S_REPORT && !SELFTEST_START_O)
    else $error("self-test repeated after pass");
  a_two_reports: assert property (@(posedge CLK_I) disable iff (RST_I)
    state_q == S_REPORT && $past(state_q) == S_BUSY
    |-> rep_cnt_q == 2'h0) else $error("report count not cleared");
  a_normal_entry: assert property (@(posedge CLK_I) disable iff (RST_I)
    $rose(state_q == S_NORMAL) |-> $past(rep_cnt_q) == 2'h1 && passed_q
    && TX_START_O && TX_KIND_O == KIND_READY) else $error("bad entry into normal");
  a_fixed_rate: assert property (@(posedge CLK_I) disable iff (RST_I)
    fr_fire && talking |=> TX_START_O && !TX_SLOT_B_O) else $error("free-run frame missed");
  a_prog_lock: assert property (@(posedge CLK_I) disable iff (RST_I)
    state_q == S_EARLY && PROG_CMD_I && config_q[CFG_LOCK_BIT]
    |=> !PROG_MODE_O) else $error("locked device entered programming");
  a_simul_latch: assert property (@(posedge CLK_I) disable iff (RST_I)
    simul_mode && sync_rise |=> data_a_q == $past(SAMPLE_I)) else $error("sync latch lost");
  a_minlat_send: assert property (@(posedge CLK_I) disable iff (RST_I)
    minlat_mode && hit_a && state_q == S_NORMAL
    |=> TX_START_O && TX_DATA_O == $past(SAMPLE_I) && data_a_q == $past(SAMPLE_I))
    else $error("slot A sample not sent");
  a_double_b: assert property (@(posedge CLK_I) disable iff (RST_I)
    double_mode && hit_b && !conflict && state_q == S_NORMAL
    |=> TX_START_O && TX_SLOT_B_O && TX_DATA_O == $past(SAMPLE_I))
    else $error("slot B sample not sent");
  a_init_same: assert property (@(posedge CLK_I) disable iff (RST_I)
    TX_START_O && TX_SLOT_B_O && TX_KIND_O != KIND_DATA
    |-> TX_DATA_O == (TX_KIND_O == KIND_BUSY ? WORD_BUSY
        : (TX_KIND_O == KIND_READY ? WORD_READY : WORD_DEFECT)))
    else $error("slot B init data differs");
  a_conflict_drop: assert property (@(posedge CLK_I) disable iff (RST_I)
    hit_b && conflict && !hit_a |=> !TX_START_O) else $error("slot B sent despite conflict");
endmodule

// file: psr_slot_if.sv
// Carrier between the scheduler and one slot offset timer.
// Assumes both ends share the scheduler clock.
`timescale 1ns/1ps
interface psr_slot_if;
  logic tick; // Half-microsecond step
  logic restart; // Sync rising edge seen
  logic [9:0] offset; // Programmed slot offset
  logic hit; // Offset reached, one cycle
  modport timer (input tick, input restart, input offset, output hit);
  modport owner (output tick, output restart, output offset, input hit);
endinterface

// file: psr_slot_timer.sv
// One-shot slot offset timer counted in half-microsecond steps.
// Assumes tick and restart come from logic on the same clock.
`timescale 1ns/1ps
module psr_slot_timer (
  input wire logic clk_i,
  input wire logic rst_i,
  psr_slot_if.timer sif
);
  logic [9:0] count_q; // Steps since the sync edge
  logic armed_q; // Waiting for the offset

  assign sif.hit = armed_q && (count_q == sif.offset);

  // Step counter, cleared at each sync edge, saturating
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      count_q <= 10'h000;
    end else if (sif.restart) begin
      count_q <= 10'h000;
    end else if (sif.tick && (count_q != 10'h3ff)) begin
      count_q <= count_q + 10'h001;
    end
  end

  // Arm at the sync edge, disarm after the hit
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      armed_q <= 1'b0;
    end else if (sif.restart) begin
      armed_q <= 1'b1;
    end else if (sif.hit) begin
      armed_q <= 1'b0;
    end
  end

  a_hit_single: assert property (@(posedge clk_i) disable iff (rst_i)
    sif.hit && !sif.restart |=> !sif.hit) else $error("slot hit repeated");
endmodule

// file: tb_top.sv
// Bench for the response scheduler: register tasks plus scripted link traffic.
// Assumes the free-run period is cut to 50 cycles for simulation.
`timescale 1ns/1ps
module tb_top;
  import psr_pkg::*;
  logic CLK_I = 1'b0, RST_I = 1'b1, SYNC_I, fire = 1'b0; // Clock, reset, sync
  logic INIT12_DONE_I = 1'b0, SELFTEST_DONE_I = 1'b0, SELFTEST_PASS_I = 1'b0;
  logic PROG_CMD_I = 1'b0, WE_I = 1'b0, RE_I = 1'b0; // Strobes
  logic [9:0] SAMPLE_I = 10'h000; // Sample feed
  logic [7:0] ADDR_I = 8'h00;
  logic [31:0] WDATA_I = 32'h0, RDATA_O, d, cfg;
  logic TX_START_O, TX_SLOT_B_O, SELFTEST_START_O, PROG_MODE_O, IRQ_O;
  logic [1:0] TX_KIND_O;
  logic [9:0] TX_DATA_O, ex;
  int n_mismatch = 0, checks_done = 0, n;
  // Sample values told apart by the frames
  localparam logic [9:0] SX = 10'h155, SY = 10'h2aa, SZ = 10'h0f0;

  always #4 CLK_I = ~CLK_I;

  psr_ecu_model ecu (.clk_i(CLK_I), .rst_i(RST_I), .fire_i(fire), .sync_o(SYNC_I));
  psr_response_scheduler #(.FREE_RUN_CYCLES(50)) dut (
    .CLK_I(CLK_I), .RST_I(RST_I), .SYNC_I(SYNC_I), .SAMPLE_I(SAMPLE_I),
    .INIT12_DONE_I(INIT12_DONE_I), .SELFTEST_DONE_I(SELFTEST_DONE_I),
    .SELFTEST_PASS_I(SELFTEST_PASS_I), .PROG_CMD_I(PROG_CMD_I), .ADDR_I(ADDR_I),
    .WDATA_I(WDATA_I), .WE_I(WE_I), .RE_I(RE_I), .RDATA_O(RDATA_O),
    .TX_START_O(TX_START_O), .TX_SLOT_B_O(TX_SLOT_B_O), .TX_KIND_O(TX_KIND_O),
    .TX_DATA_O(TX_DATA_O), .SELFTEST_START_O(SELFTEST_START_O),
    .PROG_MODE_O(PROG_MODE_O), .IRQ_O(IRQ_O));

  // Verdict and end of run
  task stop_test;
    if (n_mismatch == 0 && checks_done > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // Compare and count
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD %s exp %h seen %h", what, exp, seen);
    end
  endtask
  // One-cycle register write
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge CLK_I);
    ADDR_I <= a;
    WDATA_I <= v;
    WE_I <= 1'b1;
    @(posedge CLK_I);
    WE_I <= 1'b0;
  endtask
  // Read; data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge CLK_I);
    ADDR_I <= a;
    RE_I <= 1'b1;
    @(posedge CLK_I);
    RE_I <= 1'b0;
    #1 v = RDATA_O;
  endtask
  // Reset held for 20 cycles
  task do_reset;
    @(posedge CLK_I);
    RST_I <= 1'b1;
    repeat (20) @(posedge CLK_I);
    RST_I <= 1'b0;
  endtask
  // Ask the receiver model for one sync pulse
  task sync;
    @(posedge CLK_I);
    fire <= 1'b1;
    @(posedge CLK_I);
    fire <= 1'b0;
  endtask
  // Wait a bounded time for a frame start; n is edges waited
  task automatic wait_tx(input int lim, input logic exp, output int cnt);
    logic seen;
    seen = 1'b0;
    cnt = 0;
    while (!seen && cnt < lim) begin
      @(posedge CLK_I);
      #1 cnt++;
      seen = (TX_START_O === 1'b1);
    end
    chk("tx start", {31'h0, seen}, {31'h0, exp});
  endtask
  // Look for a self-test start pulse within five cycles
  task automatic st_start(input logic exp);
    logic seen;
    #1 seen = (SELFTEST_START_O === 1'b1); // Pulse launched at the calling edge
    repeat (4) begin
      @(posedge CLK_I);
      #1 seen = seen | (SELFTEST_START_O === 1'b1);
    end
    chk("selftest start", {31'h0, seen}, {31'h0, exp});
  endtask
  // One-cycle pulse: programming command, or phases one and two over
  task automatic pulse(input logic init);
    @(posedge CLK_I);
    PROG_CMD_I <= !init;
    INIT12_DONE_I <= init;
    @(posedge CLK_I);
    PROG_CMD_I <= 1'b0;
    INIT12_DONE_I <= 1'b0;
  endtask
  // Self-test sequence finished with the given verdict
  task automatic st_done(input logic pass);
    @(posedge CLK_I);
    SELFTEST_PASS_I <= pass;
    SELFTEST_DONE_I <= 1'b1;
    @(posedge CLK_I);
    SELFTEST_DONE_I <= 1'b0;
  endtask
  // Frame qualifiers at the last start
  task automatic frame(input logic b, input logic [1:0] k, input logic [9:0] w);
    chk("slot b", {31'h0, TX_SLOT_B_O}, {31'h0, b});
    chk("kind", {30'h0, TX_KIND_O}, {30'h0, k});
    chk("word", {22'h0, TX_DATA_O}, {22'h0, w});
  endtask

  // Hang guard
  initial begin
    repeat (90000) @(posedge CLK_I);
    n_mismatch++;
    stop_test();
  end

  // Main sequence
  initial begin
    do_reset();
    rd(OFS_CONFIG, d); chk("config rst", d, 32'h20);
    rd(OFS_SLOT_A, d); chk("slot a rst", d, 32'h0);
    rd(OFS_SLOT_B, d); chk("slot b rst", d, 32'h0);
    rd(OFS_IRQ_MASK, d); chk("mask rst", d, 32'h0);
    rd(OFS_STATUS, d); chk("state rst", d & 32'h7, 32'h0);
    rd(8'h20, d); chk("unmapped", d, 32'h0);
    // Programming entry refused while locked, taken when unlocked
    wr(OFS_CONFIG, 32'h34); pulse(1'b0);
    @(posedge CLK_I); #1 chk("prog locked", {31'h0, PROG_MODE_O}, 32'h0);
    wr(OFS_CONFIG, 32'h24); pulse(1'b0);
    @(posedge CLK_I); #1 chk("prog open", {31'h0, PROG_MODE_O}, 32'h1);
    do_reset();
    // Phase three: one failed sequence, then a pass
    wr(OFS_CONFIG, 32'h48); wr(OFS_SLOT_A, 32'h28); wr(OFS_IRQ_MASK, 32'h2);
    pulse(1'b1); st_start(1'b1);
    sync(); wait_tx(2700, 1'b1, n);
    chk("slot a time", {31'h0, n >= 2500 && n <= 2508}, 32'h1);
    frame(1'b0, KIND_BUSY, WORD_BUSY);
    st_done(1'b0); st_start(1'b1);
    chk("irq fail", {31'h0, IRQ_O}, 32'h1);
    wr(OFS_IRQ_STAT, 32'h2); @(posedge CLK_I);
    #1 chk("irq clear", {31'h0, IRQ_O}, 32'h0);
    st_done(1'b1); st_start(1'b0);
    for (int i = 0; i < 2; i++) begin
      sync(); wait_tx(2700, 1'b1, n); frame(1'b0, KIND_READY, WORD_READY);
    end
    rd(OFS_STATUS, d); chk("state normal", d & 32'h7, 32'h3);
    // Latency select: latch at hit, then latch at sync edge
    wr(OFS_IRQ_MASK, 32'h1);
    for (int i = 0; i < 2; i++) begin
      cfg = (i == 0) ? 32'h48 : 32'h40;
      ex = (i == 0) ? SY : SX;
      wr(OFS_CONFIG, cfg); SAMPLE_I <= SX; sync();
      repeat (20) @(posedge CLK_I);
      SAMPLE_I <= SY; wait_tx(2700, 1'b1, n); frame(1'b0, KIND_DATA, ex);
    end
    chk("irq frame", {31'h0, IRQ_O}, 32'h1);
    // Double rate with latency clear still latches at each hit
    wr(OFS_CONFIG, 32'h41); wr(OFS_SLOT_A, 32'h4); wr(OFS_SLOT_B, 32'hd4);
    SAMPLE_I <= SX; sync();
    repeat (20) @(posedge CLK_I);
    SAMPLE_I <= SY; wait_tx(400, 1'b1, n); frame(1'b0, KIND_DATA, SY);
    @(posedge CLK_I); SAMPLE_I <= SZ;
    wait_tx(14000, 1'b1, n); frame(1'b1, KIND_DATA, SZ);
    // Slot B starting inside the slot A frame is dropped
    wr(OFS_SLOT_B, 32'h64); sync(); wait_tx(400, 1'b1, n);
    wait_tx(7000, 1'b0, n);
    rd(OFS_IRQ_STAT, d); chk("b dropped", d & 32'h8, 32'h8);
    // Slot B ahead of slot A is no conflict
    wr(OFS_SLOT_B, 32'h0); sync();
    wait_tx(400, 1'b1, n); chk("b first", {31'h0, TX_SLOT_B_O}, 32'h1);
    wait_tx(400, 1'b1, n); chk("a second", {31'h0, TX_SLOT_B_O}, 32'h0);
    // Free-running mode needs slot A zero; period holds across a sync
    wr(OFS_CONFIG, 32'h44); wr(OFS_SLOT_A, 32'h1);
    rd(OFS_STATUS, d); chk("free_running_select off", d & 32'h200, 32'h0);
    wr(OFS_SLOT_A, 32'h0);
    rd(OFS_STATUS, d); chk("free_running_select on", d & 32'h200, 32'h200);
    wait_tx(200, 1'b1, n); sync(); wait_tx(200, 1'b1, n);
    chk("free period", n + 2, 32'd50);
    // Double rate, one retry, both sequences fail
    do_reset();
    wr(OFS_CONFIG, 32'h21); wr(OFS_SLOT_A, 32'h4); wr(OFS_SLOT_B, 32'hd4);
    pulse(1'b1); st_start(1'b1);
    st_done(1'b0); st_start(1'b1);
    st_done(1'b0); st_start(1'b0);
    sync(); wait_tx(400, 1'b1, n); frame(1'b0, KIND_DEFECT, WORD_DEFECT);
    wait_tx(14000, 1'b1, n); frame(1'b1, KIND_DEFECT, WORD_DEFECT);
    rd(OFS_STATUS, d); chk("state defect", d & 32'h7, 32'h2);
    stop_test();
  end
endmodule
